// [common/lsr_pkg.sv]
/*
 * Constants, state types and command decoding for the light sensor
 * command and readout block.
 * Assumes a 200 MHz reference clock and a bus target behind open-drain pins.
 */
package lsr_pkg;

    // ----------------------------------------------------------------
    // Bus address and command codes
    // ----------------------------------------------------------------
    localparam logic [6:0] LSR_DEV_ADDR = 7'h44;
    localparam logic [7:0] LSR_CMD_PWRDN = 8'h8c;
    localparam logic [7:0] LSR_CMD_RESET = 8'h0c;
    localparam logic [7:0] LSR_CMD_INT_MAIN = 8'h00;
    localparam logic [7:0] LSR_CMD_INT_COMP = 8'h04;
    localparam logic [7:0] LSR_CMD_INT_DIFF = 8'h08;
    localparam logic [7:0] LSR_CMD_EXT_MAIN = 8'h30;
    localparam logic [7:0] LSR_CMD_EXT_COMP = 8'h34;
    localparam logic [7:0] LSR_CMD_EXT_DIFF = 8'h38;
    localparam logic [7:0] LSR_CMD_RST_VAL = 8'h0c;
    localparam logic [15:0] LSR_RES_RST_VAL = 16'h0000;

    // ----------------------------------------------------------------
    // Read byte order and bit counts
    // ----------------------------------------------------------------
    localparam logic [1:0] LSR_IDX_RES_LO = 2'h0;
    localparam logic [1:0] LSR_IDX_CNT_LO = 2'h2;
    localparam logic [2:0] LSR_BIT_LAST = 3'h7;

    // ----------------------------------------------------------------
    // Oscillator timing
    // ----------------------------------------------------------------
    localparam int LSR_CLK_PERIOD_NS = 5;
    localparam int LSR_OSC_FREQ_HZ = 327600;
    localparam int LSR_OSC_DIV = 1000000000 / (LSR_OSC_FREQ_HZ * LSR_CLK_PERIOD_NS);
    localparam logic [9:0] LSR_DIV_LAST = 10'(LSR_OSC_DIV - 1);
    localparam int LSR_INT_CYCLES = 32768;
    localparam logic [15:0] LSR_INT_LAST = 16'(LSR_INT_CYCLES);
    localparam logic [15:0] LSR_CNT_MAX = 16'hffff;

    // ----------------------------------------------------------------
    // State types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        LSR_B_IDLE = 3'b000,
        LSR_B_ADDR = 3'b001,
        LSR_B_AACK = 3'b010,
        LSR_B_WDATA = 3'b011,
        LSR_B_WACK = 3'b100,
        LSR_B_RDATA = 3'b101,
        LSR_B_RACK = 3'b110
    } lsr_bus_e;

    typedef enum logic [1:0] {
        LSR_C_IDLE = 2'b00,
        LSR_C_RUN = 2'b01,
        LSR_C_PH2 = 2'b10
    } lsr_conv_e;

    // Internally timed conversion codes
    function automatic logic lsr_is_int(input logic [7:0] c);
        return (c == LSR_CMD_INT_MAIN) || (c == LSR_CMD_INT_COMP) || (c == LSR_CMD_INT_DIFF);
    endfunction

    // Externally timed conversion codes
    function automatic logic lsr_is_ext(input logic [7:0] c);
        return (c == LSR_CMD_EXT_MAIN) || (c == LSR_CMD_EXT_COMP) || (c == LSR_CMD_EXT_DIFF);
    endfunction

    // Bus echo test codes
    function automatic logic lsr_is_test(input logic [7:0] c);
        return c[7] && (c != LSR_CMD_PWRDN);
    endfunction

endpackage

// [src/lsr_top.sv]
/*
 * Command and readout logic of an integrating light sensor: bus target,
 * command byte, oscillator timing, integration counter and result bytes.
 * Assumes SCL/SDA and the power-down pin are asynchronous, the photocurrent
 * words come from a front end on REF_CLK, and SDA is open drain outside.
 */
`timescale 1ns/1ps

module lsr_top
    import lsr_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RESETN,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    input wire logic POWER_DOWN_INPUT,
    input wire logic [15:0] MAIN_PHOTOCURRENT,
    input wire logic [15:0] COMPENSATION_PHOTOCURRENT,
    output logic SDA_OUT,
    output logic SDA_OE_N,
    output logic CONV_BUSY,
    output logic ADC_POWERED_DOWN
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] meta_q;
    logic [2:0] sync_q;
    logic [1:0] prev_q;
    logic [2:0] meta_d;
    logic [2:0] sync_d;
    logic [1:0] prev_d;
    logic scl;
    logic sda;
    logic pd;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;

    // Two stages per pin, third stage only for edges
    always_comb
    begin
        meta_d = {POWER_DOWN_INPUT, SDA_IN, SCL_IN};
        sync_d = meta_q;
        prev_d = sync_q[1:0];
    end

    always_ff @(posedge REF_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            meta_q <= 3'h3;
            sync_q <= 3'h3;
            prev_q <= 2'h3;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    // Bus line events
    assign scl = sync_q[0];
    assign sda = sync_q[1];
    assign pd = sync_q[2];
    assign scl_rise = scl && !prev_q[0];
    assign scl_fall = !scl && prev_q[0];
    assign start_ev = scl && prev_q[0] && prev_q[1] && !sda;
    assign stop_ev = scl && prev_q[0] && !prev_q[1] && sda;

    // ----------------------------------------------------------------
    // Bus target
    // ----------------------------------------------------------------
    lsr_bus_e bst_q, bst_d;
    logic [7:0] shift_q, shift_d;
    logic [7:0] tx_q, tx_d;
    logic [7:0] cmd_q, cmd_d;
    logic [2:0] bit_q, bit_d;
    logic [1:0] idx_q, idx_d;
    logic got_q, got_d;
    logic rw_q, rw_d;
    logic nodata_q, nodata_d;
    logic oe_n_q, oe_n_d;
    logic [31:0] snap_q, snap_d;
    logic [15:0] res_q;
    logic [15:0] cres_q;
    logic cv_start;
    logic rd_load;
    logic [1:0] ld_idx;
    logic [31:0] src_word;
    logic [7:0] ld_byte;
    logic ld_allow;

    // Byte to load for the next read slot, from a snapshot
    always_comb
    begin
        ld_idx = (bst_q == LSR_B_AACK) ? LSR_IDX_RES_LO : 2'(idx_q + 2'h1);
        src_word = (bst_q == LSR_B_AACK) ? {cres_q, res_q} : snap_q;
        ld_byte = lsr_is_test(cmd_q) ? cmd_q : src_word[8 * ld_idx +: 8];
        ld_allow = (ld_idx < LSR_IDX_CNT_LO) || !lsr_is_int(cmd_q);
    end

    // Address, command and read byte sequencing
    always_comb
    begin
        bst_d = bst_q;
        shift_d = shift_q;
        tx_d = tx_q;
        cmd_d = cmd_q;
        bit_d = bit_q;
        idx_d = idx_q;
        got_d = got_q;
        rw_d = rw_q;
        nodata_d = nodata_q;
        oe_n_d = oe_n_q;
        snap_d = snap_q;
        cv_start = 1'b0;
        rd_load = 1'b0;
        if (pd)
        begin
            bst_d = LSR_B_IDLE;
            oe_n_d = 1'b1;
            nodata_d = 1'b0;
        end
        else if (start_ev)
        begin
            bst_d = LSR_B_ADDR;
            bit_d = 3'h0;
            got_d = 1'b0;
            oe_n_d = 1'b1;
            nodata_d = 1'b0;
        end
        else if (stop_ev)
        begin
            cv_start = nodata_q;
            bst_d = LSR_B_IDLE;
            oe_n_d = 1'b1;
            nodata_d = 1'b0;
        end
        else
        begin
            case (bst_q)
                LSR_B_ADDR, LSR_B_WDATA:
                begin
                    if (scl_rise)
                    begin
                        shift_d = {shift_q[6:0], sda};
                        bit_d = 3'(bit_q + 3'h1);
                        got_d = (bit_q == LSR_BIT_LAST);
                    end
                    else if (scl_fall && got_q)
                    begin
                        got_d = 1'b0;
                        bit_d = 3'h0;
                        if (bst_q == LSR_B_ADDR)
                        begin
                            if (shift_q[7:1] == LSR_DEV_ADDR)
                            begin
                                oe_n_d = 1'b0;
                                rw_d = shift_q[0];
                                nodata_d = !shift_q[0];
                                bst_d = LSR_B_AACK;
                            end
                            else
                            begin
                                bst_d = LSR_B_IDLE;
                            end
                        end
                        else
                        begin
                            oe_n_d = 1'b0;
                            cmd_d = shift_q;
                            cv_start = 1'b1;
                            nodata_d = 1'b0;
                            bst_d = LSR_B_WACK;
                        end
                    end
                end
                LSR_B_AACK, LSR_B_RACK:
                begin
                    if (bst_q == LSR_B_RACK && scl_rise)
                    begin
                        got_d = !sda;
                        bst_d = sda ? LSR_B_IDLE : LSR_B_RACK;
                    end
                    else if (scl_fall && (bst_q == LSR_B_AACK || got_q))
                    begin
                        got_d = 1'b0;
                        bit_d = 3'h0;
                        if (bst_q == LSR_B_AACK && !rw_q)
                        begin
                            oe_n_d = 1'b1;
                            bst_d = LSR_B_WDATA;
                        end
                        else
                        begin
                            rd_load = 1'b1;
                            idx_d = ld_idx;
                            tx_d = ld_byte;
                            oe_n_d = ld_byte[7] || !ld_allow;
                            if (bst_q == LSR_B_AACK)
                            begin
                                snap_d = {cres_q, res_q};
                            end
                            bst_d = LSR_B_RDATA;
                        end
                    end
                end
                LSR_B_WACK:
                begin
                    if (scl_fall)
                    begin
                        oe_n_d = 1'b1;
                        bst_d = LSR_B_WDATA;
                    end
                end
                LSR_B_RDATA:
                begin
                    if (scl_fall)
                    begin
                        if (bit_q == LSR_BIT_LAST)
                        begin
                            oe_n_d = 1'b1;
                            bst_d = LSR_B_RACK;
                        end
                        else
                        begin
                            bit_d = 3'(bit_q + 3'h1);
                            tx_d = {tx_q[6:0], 1'b0};
                            oe_n_d = tx_q[6]
                                || (lsr_is_int(cmd_q) && idx_q >= LSR_IDX_CNT_LO);
                        end
                    end
                end
                default:
                begin
                    bst_d = LSR_B_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            bst_q <= LSR_B_IDLE;
            shift_q <= 8'h00;
            tx_q <= 8'h00;
            cmd_q <= LSR_CMD_RST_VAL;
            bit_q <= 3'h0;
            idx_q <= 2'h0;
            got_q <= 1'b0;
            rw_q <= 1'b0;
            nodata_q <= 1'b0;
            oe_n_q <= 1'b1;
            snap_q <= 32'h0000_0000;
        end
        else
        begin
            bst_q <= bst_d;
            shift_q <= shift_d;
            tx_q <= tx_d;
            cmd_q <= cmd_d;
            bit_q <= bit_d;
            idx_q <= idx_d;
            got_q <= got_d;
            rw_q <= rw_d;
            nodata_q <= nodata_d;
            oe_n_q <= oe_n_d;
            snap_q <= snap_d;
        end
    end

    // ----------------------------------------------------------------
    // Conversion timing and results
    // ----------------------------------------------------------------
    lsr_conv_e cst_q, cst_d;
    logic [9:0] div_q, div_d;
    logic [15:0] icnt_q, icnt_d;
    logic [15:0] hold_q, hold_d;
    logic [15:0] res_d;
    logic [15:0] cres_d;
    logic [7:0] run_q, run_d;
    logic busy_q, busy_d;
    logic pwr_q, pwr_d;
    logic tick;
    logic latch;
    logic [15:0] lat_cnt;
    logic [15:0] cnt_inc;

    assign tick = (div_q == LSR_DIV_LAST);
    assign cnt_inc = 16'(icnt_q + 16'h0001);

    // Integration sequencing and result latch
    always_comb
    begin
        cst_d = cst_q;
        div_d = tick ? 10'h000 : 10'(div_q + 10'h001);
        icnt_d = icnt_q;
        hold_d = hold_q;
        res_d = res_q;
        cres_d = cres_q;
        run_d = run_q;
        latch = 1'b0;
        lat_cnt = icnt_q;
        if (pd)
        begin
            cst_d = LSR_C_IDLE;
        end
        else if (cv_start)
        begin
            run_d = cmd_d;
            icnt_d = 16'h0000;
            if (cmd_d == LSR_CMD_RESET)
            begin
                res_d = LSR_RES_RST_VAL;
                cres_d = LSR_RES_RST_VAL;
                cst_d = LSR_C_IDLE;
            end
            else if (lsr_is_ext(cmd_d))
            begin
                latch = (cst_q != LSR_C_IDLE) && (cmd_d == run_q);
                cst_d = LSR_C_RUN;
            end
            else
            begin
                cst_d = lsr_is_int(cmd_d) ? LSR_C_RUN : LSR_C_IDLE;
            end
        end
        else if (cst_q != LSR_C_IDLE && tick)
        begin
            if (lsr_is_ext(run_q))
            begin
                icnt_d = (icnt_q == LSR_CNT_MAX) ? LSR_CNT_MAX : cnt_inc;
            end
            else if (cnt_inc == LSR_INT_LAST)
            begin
                icnt_d = 16'h0000;
                lat_cnt = cnt_inc;
                if (run_q == LSR_CMD_INT_DIFF && cst_q == LSR_C_RUN)
                begin
                    hold_d = COMPENSATION_PHOTOCURRENT;
                    cst_d = LSR_C_PH2;
                end
                else
                begin
                    latch = 1'b1;
                    cst_d = LSR_C_RUN;
                end
            end
            else
            begin
                icnt_d = cnt_inc;
            end
        end
        if (latch)
        begin
            cres_d = lat_cnt;
            case (run_q[3:2])
                2'h0: res_d = MAIN_PHOTOCURRENT;
                2'h1: res_d = COMPENSATION_PHOTOCURRENT;
                default: res_d = 16'(MAIN_PHOTOCURRENT - (lsr_is_ext(run_q) ?
                    COMPENSATION_PHOTOCURRENT : hold_q));
            endcase
        end
        busy_d = (cst_d != LSR_C_IDLE);
        pwr_d = pd || (run_d == LSR_CMD_PWRDN);
    end

    always_ff @(posedge REF_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            cst_q <= LSR_C_IDLE;
            div_q <= 10'h000;
            icnt_q <= 16'h0000;
            hold_q <= 16'h0000;
            res_q <= LSR_RES_RST_VAL;
            cres_q <= LSR_RES_RST_VAL;
            run_q <= LSR_CMD_RST_VAL;
            busy_q <= 1'b0;
            pwr_q <= 1'b0;
        end
        else
        begin
            cst_q <= cst_d;
            div_q <= div_d;
            icnt_q <= icnt_d;
            hold_q <= hold_d;
            res_q <= res_d;
            cres_q <= cres_d;
            run_q <= run_d;
            busy_q <= busy_d;
            pwr_q <= pwr_d;
        end
    end

    // Outputs from flip-flops; SDA only ever pulled low
    assign SDA_OUT = 1'b0 & oe_n_q;
    assign SDA_OE_N = oe_n_q;
    assign CONV_BUSY = busy_q;
    assign ADC_POWERED_DOWN = pwr_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);

    a_addr_match: assert property (
        (bst_q == LSR_B_AACK) |-> (shift_q[7:1] == LSR_DEV_ADDR && !oe_n_q))
        else $error("address acknowledged for wrong target");
    a_cmd_write: assert property (
        (bst_q == LSR_B_WDATA && scl_fall && got_q && !pd && !start_ev && !stop_ev)
        |=> (cmd_q == $past(shift_q) && bst_q == LSR_B_WACK))
        else $error("command not replaced by written byte");
    a_cmd_hold: assert property (
        (bst_q != LSR_B_WDATA) |=> $stable(cmd_q))
        else $error("command changed without a write");
    a_read_first: assert property (
        (rd_load && bst_q == LSR_B_AACK && !lsr_is_test(cmd_q)) |=> (tx_q == $past(res_q[7:0])))
        else $error("first read byte not result low");
    a_test_echo: assert property (
        (rd_load && lsr_is_test(cmd_q)) |=> (tx_q == $past(cmd_q)))
        else $error("test mode does not echo command");
    a_int_nak: assert property (
        (bst_q == LSR_B_RDATA && idx_q >= LSR_IDX_CNT_LO && lsr_is_int(cmd_q)) |-> oe_n_q)
        else $error("count bytes driven in internal mode");
    a_res_stable: assert property (
        (!latch && !(cv_start && cmd_d == LSR_CMD_RESET)) |=> $stable(res_q))
        else $error("result changed outside completion");
    a_int_period: assert property (
        (latch && lsr_is_int(run_q)) |=> (cres_q == LSR_INT_LAST))
        else $error("internal period not 32768 cycles");
    a_cnt_sat: assert property (
        (tick && !cv_start && !pd && cst_q != LSR_C_IDLE && lsr_is_ext(run_q)
        && icnt_q == LSR_CNT_MAX) |=> (icnt_q == LSR_CNT_MAX))
        else $error("external count wrapped");
    a_diff_sub: assert property (
        (latch && run_q == LSR_CMD_INT_DIFF)
        |=> (res_q == 16'($past(MAIN_PHOTOCURRENT) - $past(hold_q))))
        else $error("difference result wrong");
    a_rerun_cmd: assert property (
        (stop_ev && nodata_q && !pd) |-> (cv_start && cmd_d == cmd_q))
        else $error("empty write did not rerun command");
    a_pd_quiet: assert property (
        pd |=> (oe_n_q && !busy_q && pwr_q))
        else $error("power-down pin ignored");

    c_ext_latch: cover property (latch && lsr_is_ext(run_q));
    c_diff_ph2: cover property (cst_q == LSR_C_PH2 ##1 latch);
    c_four_bytes: cover property (rd_load && idx_d == 2'h3);
    c_rerun: cover property (stop_ev && nodata_q);

endmodule

// [bench/lsr_master.sv]
/*
 * Bus master model that drives the clock and data lines of the sensor bus.
 * Assumes the bench resolves the open-drain data wire with a pull-up.
 */
`timescale 1ns/1ps
module lsr_master
(
    output logic scl,
    output logic sda_m,
    input wire logic sda
);
    // ------------------------------------------------------------
    // Bit, byte and framing tasks, 48 ns clock period
    // ------------------------------------------------------------
    // Idle bus, both lines released, clock still outside frames
    initial
    begin
        scl = 1'b1;
        sda_m = 1'b1;
    end

    // Data set mid low phase, sampled on the rising clock
    task automatic bit_x(input logic b, output logic r);
        #12 sda_m = b;
        #12 scl = 1'b1;
        r = sda;
        #24 scl = 1'b0;
    endtask

    // Start: data falls while clock high
    task automatic start();
        #12 sda_m = 1'b0;
        #12 scl = 1'b0;
    endtask

    // Stop: data rises while clock high
    task automatic stop();
        #12 sda_m = 1'b0;
        #12 scl = 1'b1;
        #12 sda_m = 1'b1;
        #12;
    endtask

    // Byte out, then release data for the target's answer
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = ~r;
    endtask

    // Byte in, then acknowledge if more bytes are wanted
    task automatic rbyte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(1'b1, d[i]);
        bit_x(~more, r);
    endtask
endmodule

// [bench/light_sensor_i2c_command_readout_bench.sv]
/*
 * Self-checking bench for the light sensor command and readout block.
 * Assumes the design package and the bus master model are compiled first.
 */
`timescale 1ns/1ps
module light_sensor_i2c_command_readout_bench
    import lsr_pkg::*;
;
    // ------------------------------------------------------------
    // Signals, design, master model
    // ------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic resetn, pwr_dn_in, sda_oe_n, sda_out, conv_busy, adc_off, scl, sda_m, ack;
    logic [15:0] main_pc, comp_pc;
    logic [31:0] rv, prev;
    logic [7:0] d;
    logic [6:0] a;
    logic [7:0] codes [3] = '{LSR_CMD_EXT_MAIN, LSR_CMD_EXT_COMP, LSR_CMD_EXT_DIFF};
    int err_total, check_count, seed, n, tk, dt, nrd;
    realtime t0;
    wire sda = sda_m & (sda_oe_n | sda_out);

    always #2.5 ref_clk = ~ref_clk;

    lsr_top uut (.REF_CLK(ref_clk), .RESETN(resetn), .SCL_IN(scl), .SDA_IN(sda),
        .POWER_DOWN_INPUT(pwr_dn_in), .MAIN_PHOTOCURRENT(main_pc),
        .COMPENSATION_PHOTOCURRENT(comp_pc), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n),
        .CONV_BUSY(conv_busy), .ADC_POWERED_DOWN(adc_off));
    lsr_master m (.scl(scl), .sda_m(sda_m), .sda(sda));

    // Compare and report
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Verdict and end of run
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic w(input int k);
        repeat (k) @(negedge ref_clk);
    endtask

    // Write transaction, command byte optional
    task automatic wr(input logic [6:0] ad, input logic [7:0] c, input logic has,
        output logic ok);
        logic k;
        m.start();
        m.wbyte({ad, 1'b0}, ok);
        if (has)
            m.wbyte(c, k);
        m.stop();
    endtask

    // Read of nrd bytes, last one not acknowledged; unread bytes stay all ones
    task automatic rd(output logic [31:0] v);
        logic k;
        logic [7:0] b;
        v = '1;
        m.start();
        m.wbyte({LSR_DEV_ADDR, 1'b1}, k);
        for (int i = 0; i < nrd; i++)
        begin
            m.rbyte(i < nrd - 1, b);
            v[8*i+:8] = b;
        end
        m.stop();
    endtask

    // Expected result word of an externally timed code
    function automatic logic [15:0] exp_res(input logic [7:0] c);
        case (c)
            LSR_CMD_EXT_MAIN: return main_pc;
            LSR_CMD_EXT_COMP: return comp_pc;
            default: return 16'(main_pc - comp_pc);
        endcase
    endfunction

    // Hang guard
    initial
    begin
        repeat (100000) @(posedge ref_clk);
        err_total++;
        results();
    end

    // Main sequence
    initial
    begin
        err_total = 0;
        check_count = 0;
        nrd = 4;
        seed = $urandom(32'h4409f9a2);
        resetn = 1'b0;
        pwr_dn_in = 1'b0;
        main_pc = 16'h0000;
        comp_pc = 16'h0000;
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        resetn = 1'b1;
        w(4);
        chk({conv_busy, adc_off, sda_oe_n, sda_out}, 4'h2);
        rd(rv);
        chk(rv, 32'h0);
        $display("test reset done");
        a = 7'($urandom);
        if (a == LSR_DEV_ADDR)
            a = 7'h45;
        wr(a, LSR_CMD_EXT_MAIN, 1'b1, ack);
        w(4);
        chk({ack, conv_busy}, 2'b00);
        repeat (4)
        begin
            d = 8'($urandom) | 8'h80;
            if (d == LSR_CMD_PWRDN)
                d = 8'h8d;
            wr(LSR_DEV_ADDR, d, 1'b1, ack);
            rd(rv);
            chk({ack, rv}, {1'b1, {4{d}}});
        end
        $display("test address and echo done");
        wr(LSR_DEV_ADDR, LSR_CMD_PWRDN, 1'b1, ack);
        w(4);
        chk({ack, adc_off, conv_busy}, 3'b110);
        wr(LSR_DEV_ADDR, LSR_CMD_RESET, 1'b1, ack);
        w(4);
        rd(rv);
        chk({adc_off, rv}, 33'h0);
        prev = 32'h0;
        foreach (codes[j])
        begin
            wr(LSR_DEV_ADDR, codes[j], 1'b1, ack);
            t0 = $realtime;
            n = 2 + $urandom % 6;
            repeat (n * LSR_OSC_DIV) @(negedge ref_clk);
            main_pc = 16'($urandom);
            comp_pc = 16'($urandom);
            rd(rv);
            chk({conv_busy, rv}, {1'b1, prev});
            wr(LSR_DEV_ADDR, codes[j], 1'b1, ack);
            tk = int'(($realtime - t0) / (LSR_OSC_DIV * LSR_CLK_PERIOD_NS));
            rd(rv);
            chk(rv[15:0], exp_res(codes[j]));
            dt = int'(rv[31:16]) - tk;
            chk(40'(dt >= -1 && dt <= 1), 40'h1);
            prev = rv;
        end
        $display("test external timing done");
        // New input, so the rerun of the stored difference code shows its latch
        main_pc = 16'($urandom);
        wr(LSR_DEV_ADDR, 8'h00, 1'b0, ack);
        w(4);
        rd(rv);
        chk({ack, conv_busy, rv[15:0]}, {2'b11, exp_res(LSR_CMD_EXT_DIFF)});
        prev = rv;
        // Internal codes are the external ones without timing bits; read early
        foreach (codes[j])
        begin
            wr(LSR_DEV_ADDR, codes[j] & 8'h0f, 1'b1, ack);
            w(4);
            rd(rv);
            chk({conv_busy, rv}, {1'b1, 16'hffff, prev[15:0]});
        end
        // Short read: stop right after the two result bytes
        nrd = 2;
        rd(rv);
        chk(rv, {16'hffff, prev[15:0]});
        nrd = 4;
        $display("test internal timing done");
        @(negedge ref_clk);
        pwr_dn_in = 1'b1;
        w(4);
        wr(LSR_DEV_ADDR, LSR_CMD_EXT_MAIN, 1'b1, ack);
        chk({ack, adc_off}, 2'b01);
        @(negedge ref_clk);
        pwr_dn_in = 1'b0;
        w(4);
        chk(adc_off, 1'b0);
        $display("test power-down pin done");
        results();
    end
endmodule
